//--- rtl/pmra_pkg.sv
// Package for the power monitor result and alert block.
// Assumes a register access port driven by a serial-bus slave elsewhere.
package pmra_pkg;
   // ==========================================================
   // Register offsets (pointer values)
   localparam logic [7:0] SHUNT_OFS = 8'h01;
   localparam logic [7:0] BUS_OFS = 8'h02;
   localparam logic [7:0] POWER_OFS = 8'h03;
   localparam logic [7:0] CURRENT_OFS = 8'h04;
   localparam logic [7:0] SCALE_OFS = 8'h05;
   localparam logic [7:0] ALERT_CTL_OFS = 8'h06;
   localparam logic [7:0] LIMIT_OFS = 8'h07;
   localparam logic [7:0] CONFIG_OFS = 8'h00;
   // ==========================================================
   // Reset values
   localparam logic [15:0] SCALE_RST = 16'h0000;
   localparam logic [15:0] ALERT_CTL_RST = 16'h0000;
   localparam logic [15:0] LIMIT_RST = 16'h0000;
   localparam logic [15:0] RESULT_RST = 16'h0000;
   // ==========================================================
   // Alert control field positions
   localparam int SHUNT_OVER_POS = 15;
   localparam int SHUNT_UNDER_POS = 14;
   localparam int BUS_OVER_POS = 13;
   localparam int BUS_UNDER_POS = 12;
   localparam int POWER_OVER_POS = 11;
   localparam int RDY_EN_POS = 10;
   localparam int AFLAG_POS = 4;
   localparam int DONE_POS = 3;
   localparam int OVERFLOW_POS = 2;
   localparam int ALERT_LEVEL_POS = 1;
   localparam int LATCH_POS = 0;
   localparam logic [15:0] CTL_WMASK = 16'hfc03;
   localparam logic [15:0] SCALE_WMASK = 16'h7fff;
   // ==========================================================
   // Arithmetic constants
   localparam int POWER_DIV = 25;
   localparam logic [2:0] MODE_TRIG_MASK = 3'h4;
   // ==========================================================
   // Carriers
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [15:0] wdata;
   } pmra_reg_req_type;
   typedef struct packed {
      logic valid;
      logic [15:0] shunt;
      logic [15:0] bus;
   } pmra_sample_type;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CURR,
      ST_POWER,
      ST_DONE
   } pmra_state_type;
endpackage

//--- rtl/pmra_core.sv
// Result calculation and alert logic of the power monitor.
// Assumes the sample and register requests come from ref_clk logic.
`timescale 1ns/1ps
module pmra_core #(
   parameter int DATA_W = 16
) (
   input wire logic ref_clk,
   input wire logic rst,
   input pmra_pkg::pmra_reg_req_type reg_req,
   input pmra_pkg::pmra_sample_type sample,
   input wire logic [2:0] op_mode,
   output logic [15:0] reg_rdata,
   output logic alert_out,
   output logic alert_oe
);
   initial begin
      if (DATA_W != 16) begin
         $error("pmra_core supports only 16-bit data");
      end
   end

   // ==========================================================
   // Register requests
   logic ctl_rd, cfg_wr, trig_mode;
   assign ctl_rd = reg_req.rd && reg_req.addr == pmra_pkg::ALERT_CTL_OFS;
   assign cfg_wr = reg_req.wr && reg_req.addr == pmra_pkg::CONFIG_OFS &&
      reg_req.wdata[1:0] != 2'h0;
   assign trig_mode = (op_mode & pmra_pkg::MODE_TRIG_MASK) == 3'h0;

   logic [15:0] scale_reg, scale_next;
   logic [15:0] limit_reg, limit_next;
   logic [15:0] ctl_reg, ctl_next;
   logic [15:0] shunt_reg, shunt_next, bus_reg, bus_next;
   logic [15:0] current_reg, current_next, power_reg, power_next;
   logic aflag_reg, aflag_next, done_reg, done_next, ovf_reg, ovf_next;
   logic alert_out_reg, alert_out_next;
   logic alert_oe_reg;
   logic [15:0] rdata_reg, rdata_next;
   pmra_pkg::pmra_state_type state_reg, state_next;

   // ==========================================================
   // Arithmetic
   logic signed [31:0] cur_prod;
   logic signed [31:0] pow_prod;
   logic signed [31:0] pow_scaled;
   logic cur_ovf, pow_ovf;
   assign cur_prod = $signed(shunt_reg) *
      $signed({1'b0, scale_reg[14:0]});
   // Shift by the calibration scaling implied by the sample LSBs
   logic signed [31:0] cur_shift;
   assign cur_shift = cur_prod >>> 11;
   assign cur_ovf = cur_shift > 32'sd32767 || cur_shift < -32'sd32768;
   assign pow_prod = $signed(current_reg) *
      $signed({1'b0, bus_reg[14:0]});
   logic signed [31:0] pow_abs;
   assign pow_abs = pow_prod < 0 ? -pow_prod : pow_prod;
   assign pow_scaled = pow_abs / pmra_pkg::POWER_DIV;
   assign pow_ovf = pow_scaled > 32'sd65535;

   // ==========================================================
   // Limit comparison, once per finished result
   logic lim_hit;
   always_comb begin
      lim_hit = 1'b0;
      if (ctl_reg[pmra_pkg::SHUNT_OVER_POS]) begin
         lim_hit = $signed(shunt_reg) > $signed(limit_reg);
      end else if (ctl_reg[pmra_pkg::SHUNT_UNDER_POS]) begin
         lim_hit = $signed(shunt_reg) < $signed(limit_reg);
      end else if (ctl_reg[pmra_pkg::BUS_OVER_POS]) begin
         lim_hit = bus_reg > limit_reg;
      end else if (ctl_reg[pmra_pkg::BUS_UNDER_POS]) begin
         lim_hit = bus_reg < limit_reg;
      end else if (ctl_reg[pmra_pkg::POWER_OVER_POS]) begin
         lim_hit = power_reg > limit_reg;
      end
   end

   // ==========================================================
   // Next-state logic
   logic latched, alert_act;
   assign latched = ctl_reg[pmra_pkg::LATCH_POS];
   always_comb begin
      state_next = state_reg;
      shunt_next = shunt_reg;
      bus_next = bus_reg;
      current_next = current_reg;
      power_next = power_reg;
      scale_next = scale_reg;
      limit_next = limit_reg;
      ctl_next = ctl_reg;
      aflag_next = aflag_reg;
      done_next = done_reg;
      ovf_next = ovf_reg;
      alert_act = 1'b0;
      if (reg_req.wr) begin
         case (reg_req.addr)
            pmra_pkg::SCALE_OFS:
               scale_next = reg_req.wdata & pmra_pkg::SCALE_WMASK;
            pmra_pkg::LIMIT_OFS: limit_next = reg_req.wdata;
            pmra_pkg::ALERT_CTL_OFS:
               ctl_next = reg_req.wdata & pmra_pkg::CTL_WMASK;
            default: ;
         endcase
      end
      // Clears first so that a same-cycle set wins
      if (ctl_rd && latched) begin
         aflag_next = 1'b0;
      end
      if (trig_mode && (ctl_rd || cfg_wr)) begin
         done_next = 1'b0;
      end
      case (state_reg)
         pmra_pkg::ST_IDLE: begin
            if (sample.valid) begin
               // Samples arrive already averaged when enabled
               shunt_next = sample.shunt;
               bus_next = sample.bus;
               state_next = pmra_pkg::ST_CURR;
            end
         end
         pmra_pkg::ST_CURR: begin
            current_next = cur_shift[15:0];
            ovf_next = cur_ovf;
            state_next = pmra_pkg::ST_POWER;
         end
         pmra_pkg::ST_POWER: begin
            power_next = pow_scaled[15:0];
            ovf_next = ovf_reg | pow_ovf;
            state_next = pmra_pkg::ST_DONE;
         end
         pmra_pkg::ST_DONE: begin
            done_next = 1'b1;
            if (lim_hit) begin
               aflag_next = 1'b1;
            end else if (!latched) begin
               aflag_next = 1'b0;
            end
            state_next = pmra_pkg::ST_IDLE;
         end
         default: state_next = pmra_pkg::ST_IDLE;
      endcase
      alert_act = aflag_next ||
         (ctl_reg[pmra_pkg::RDY_EN_POS] && done_next);
      alert_out_next = ctl_reg[pmra_pkg::ALERT_LEVEL_POS] ?
         alert_act : !alert_act;
   end

   // ==========================================================
   // Read data
   logic [15:0] ctl_view;
   always_comb begin
      ctl_view = ctl_reg;
      ctl_view[pmra_pkg::AFLAG_POS] = aflag_reg;
      ctl_view[pmra_pkg::DONE_POS] = done_reg;
      ctl_view[pmra_pkg::OVERFLOW_POS] = ovf_reg;
      case (reg_req.addr)
         pmra_pkg::SHUNT_OFS: rdata_next = shunt_reg;
         pmra_pkg::BUS_OFS: rdata_next = bus_reg;
         pmra_pkg::POWER_OFS: rdata_next = power_reg;
         pmra_pkg::CURRENT_OFS: rdata_next = current_reg;
         pmra_pkg::SCALE_OFS: rdata_next = scale_reg;
         pmra_pkg::ALERT_CTL_OFS: rdata_next = ctl_view;
         pmra_pkg::LIMIT_OFS: rdata_next = limit_reg;
         default: rdata_next = 16'h0000;
      endcase
      if (!reg_req.rd) begin
         rdata_next = rdata_reg;
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_reg <= pmra_pkg::ST_IDLE;
         shunt_reg <= pmra_pkg::RESULT_RST;
         bus_reg <= pmra_pkg::RESULT_RST;
         current_reg <= pmra_pkg::RESULT_RST;
         power_reg <= pmra_pkg::RESULT_RST;
         scale_reg <= pmra_pkg::SCALE_RST;
         limit_reg <= pmra_pkg::LIMIT_RST;
         ctl_reg <= pmra_pkg::ALERT_CTL_RST;
         aflag_reg <= 1'b0;
         done_reg <= 1'b0;
         ovf_reg <= 1'b0;
         alert_out_reg <= 1'b1;
         alert_oe_reg <= 1'b0;
         rdata_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         shunt_reg <= shunt_next;
         bus_reg <= bus_next;
         current_reg <= current_next;
         power_reg <= power_next;
         scale_reg <= scale_next;
         limit_reg <= limit_next;
         ctl_reg <= ctl_next;
         aflag_reg <= aflag_next;
         done_reg <= done_next;
         ovf_reg <= ovf_next;
         alert_out_reg <= alert_out_next;
         alert_oe_reg <= 1'b1;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign alert_out = alert_out_reg;
   // Pin is driven once reset has released; idle level comes from alert_out
   assign alert_oe = alert_oe_reg;

   // ==========================================================
   // Assertions, register side
   scale_msb_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      !scale_reg[15])
      else $error("scale top bit set");
   limit_write_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      reg_req.wr && reg_req.addr == pmra_pkg::LIMIT_OFS
      |=> limit_reg == $past(reg_req.wdata))
      else $error("limit write lost");
   ctl_ro_bits_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      (ctl_reg & ~pmra_pkg::CTL_WMASK) == 16'h0000)
      else $error("control read-only bits set");
   trig_clear_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      trig_mode && ctl_rd && state_reg != pmra_pkg::ST_DONE
      |=> !done_reg)
      else $error("ready flag not cleared");
   cfg_clear_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      trig_mode && cfg_wr && state_reg != pmra_pkg::ST_DONE
      |=> !done_reg)
      else $error("ready flag kept after config write");

   // ==========================================================
   // Assertions, calculation
   done_set_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      state_reg == pmra_pkg::ST_DONE
      |=> done_reg)
      else $error("ready flag not set");
   pipe_order_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      sample.valid && state_reg == pmra_pkg::ST_IDLE
      |=> state_reg == pmra_pkg::ST_CURR
      ##1 state_reg == pmra_pkg::ST_POWER
      ##1 state_reg == pmra_pkg::ST_DONE)
      else $error("calculation sequence broken");
   ovf_set_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      state_reg == pmra_pkg::ST_CURR && cur_ovf
      |-> ##2 ovf_reg)
      else $error("overflow flag missed");
   busy_ignore_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      sample.valid && state_reg != pmra_pkg::ST_IDLE
      |=> $stable(shunt_reg) && $stable(bus_reg))
      else $error("sample taken while busy");

   // ==========================================================
   // Assertions, limit functions
   shunt_over_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      state_reg == pmra_pkg::ST_DONE &&
      ctl_reg[pmra_pkg::SHUNT_OVER_POS] &&
      $signed(shunt_reg) > $signed(limit_reg)
      |=> aflag_reg)
      else $error("shunt over limit missed");
   shunt_under_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      state_reg == pmra_pkg::ST_DONE &&
      !ctl_reg[pmra_pkg::SHUNT_OVER_POS] &&
      ctl_reg[pmra_pkg::SHUNT_UNDER_POS] &&
      $signed(shunt_reg) < $signed(limit_reg)
      |=> aflag_reg)
      else $error("shunt under limit missed");
   bus_over_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      state_reg == pmra_pkg::ST_DONE &&
      !ctl_reg[pmra_pkg::SHUNT_OVER_POS] &&
      !ctl_reg[pmra_pkg::SHUNT_UNDER_POS] &&
      ctl_reg[pmra_pkg::BUS_OVER_POS] &&
      bus_reg > limit_reg
      |=> aflag_reg)
      else $error("bus over limit missed");
   bus_under_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      state_reg == pmra_pkg::ST_DONE &&
      !ctl_reg[pmra_pkg::SHUNT_OVER_POS] &&
      !ctl_reg[pmra_pkg::SHUNT_UNDER_POS] &&
      !ctl_reg[pmra_pkg::BUS_OVER_POS] &&
      ctl_reg[pmra_pkg::BUS_UNDER_POS] &&
      bus_reg < limit_reg
      |=> aflag_reg)
      else $error("bus under limit missed");
   power_over_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      state_reg == pmra_pkg::ST_DONE &&
      !ctl_reg[pmra_pkg::SHUNT_OVER_POS] &&
      !ctl_reg[pmra_pkg::SHUNT_UNDER_POS] &&
      !ctl_reg[pmra_pkg::BUS_OVER_POS] &&
      !ctl_reg[pmra_pkg::BUS_UNDER_POS] &&
      ctl_reg[pmra_pkg::POWER_OVER_POS] &&
      power_reg > limit_reg
      |=> aflag_reg)
      else $error("power over limit missed");
   prio_pick_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      state_reg == pmra_pkg::ST_DONE && !latched &&
      ctl_reg[pmra_pkg::SHUNT_OVER_POS] &&
      $signed(shunt_reg) <= $signed(limit_reg)
      |=> !aflag_reg)
      else $error("lower limit function took over");
   flag_set_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      state_reg == pmra_pkg::ST_DONE && lim_hit
      |=> aflag_reg)
      else $error("limit hit missed");
   trans_clear_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      state_reg == pmra_pkg::ST_DONE && !lim_hit && !latched
      |=> !aflag_reg)
      else $error("transparent flag stuck");
   latch_hold_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      aflag_reg && latched && !ctl_rd && $stable(ctl_reg)
      |=> aflag_reg)
      else $error("latched flag dropped");
   latch_clear_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      ctl_rd && latched && state_reg != pmra_pkg::ST_DONE
      |=> !aflag_reg)
      else $error("latched flag not cleared");

   // ==========================================================
   // Assertions, alert pin
   level_sel_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      aflag_reg && $stable(aflag_reg) && $stable(ctl_reg)
      |-> alert_out == ctl_reg[pmra_pkg::ALERT_LEVEL_POS])
      else $error("alert level wrong");
   idle_level_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      !aflag_reg && !done_reg && $stable(ctl_reg)
      |-> alert_out == !ctl_reg[pmra_pkg::ALERT_LEVEL_POS])
      else $error("alert not idle");
   ready_alert_a: assert property (
      @(posedge ref_clk) disable iff (rst)
      state_reg == pmra_pkg::ST_DONE &&
      ctl_reg[pmra_pkg::RDY_EN_POS] && !reg_req.wr
      |=> alert_out == ctl_reg[pmra_pkg::ALERT_LEVEL_POS])
      else $error("ready alert missed");

   // ==========================================================
   // Covers
   conv_c: cover property (@(posedge ref_clk) disable iff (rst)
      state_reg == pmra_pkg::ST_DONE);
   hit_c: cover property (@(posedge ref_clk) disable iff (rst)
      state_reg == pmra_pkg::ST_DONE && lim_hit && latched);
   ovf_c: cover property (@(posedge ref_clk) disable iff (rst)
      $rose(ovf_reg));
   rdy_c: cover property (@(posedge ref_clk) disable iff (rst)
      state_reg == pmra_pkg::ST_DONE && ctl_reg[pmra_pkg::RDY_EN_POS]);
   clr_c: cover property (@(posedge ref_clk) disable iff (rst)
      ctl_rd && latched && aflag_reg);
endmodule

//--- dv/pmra_host_model.sv
// Host-side model that issues register requests and measurement samples.
// Assumes the core samples its inputs on the rising edge of ref_clk.
`timescale 1ns/1ps
module pmra_host_model (
   input wire logic ref_clk,
   input wire logic [15:0] reg_rdata,
   output pmra_pkg::pmra_reg_req_type reg_req,
   output pmra_pkg::pmra_sample_type sample
);
   // ==========================================================
   // Idle state and request tasks
   initial begin
      reg_req = '0;
      sample = '0;
   end
   task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
      @(negedge ref_clk);
      reg_req.wr = 1'b1;
      reg_req.addr = a;
      reg_req.wdata = d;
      @(negedge ref_clk);
      reg_req.wr = 1'b0;
      reg_req.addr = ~a;
      reg_req.wdata = ~d;
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
      @(negedge ref_clk);
      reg_req.rd = 1'b1;
      reg_req.addr = a;
      @(negedge ref_clk);
      reg_req.rd = 1'b0;
      reg_req.addr = ~a;
      d = reg_rdata;
   endtask
   // Released data lines show the inverse so stale values cannot match
   task automatic send(input logic [15:0] sh, input logic [15:0] bu);
      @(negedge ref_clk);
      sample.valid = 1'b1;
      sample.shunt = sh;
      sample.bus = bu;
      @(negedge ref_clk);
      sample.valid = 1'b0;
      sample.shunt = ~sh;
      sample.bus = ~bu;
      repeat (6) @(negedge ref_clk);
   endtask
endmodule

//--- dv/power_monitor_result_and_alert_tb_top.sv
// Self-checking bench for the result and alert core.
// Assumes the host model drives all requests at the falling edge.
`timescale 1ns/1ps
module power_monitor_result_and_alert_tb_top;
   logic ref_clk;
   logic rst;
   logic [2:0] op_mode;
   pmra_pkg::pmra_reg_req_type reg_req;
   pmra_pkg::pmra_sample_type sample;
   logic [15:0] reg_rdata;
   logic [15:0] rd;
   logic alert_out;
   logic alert_oe;
   int mismatches;
   int total_checks;
   int cycles;
   pmra_core dut_u (.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req),
      .sample(sample), .op_mode(op_mode), .reg_rdata(reg_rdata),
      .alert_out(alert_out), .alert_oe(alert_oe));
   pmra_host_model host_u (.ref_clk(ref_clk), .reg_rdata(reg_rdata),
      .reg_req(reg_req), .sample(sample));
   // ==========================================================
   // Clock, timeout and reporting
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      check({15'h0000, got}, {15'h0000, exp});
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      for (int a = 3; a < 7; a++) begin
         host_u.reg_read(8'(a), rd);
         check(rd, 16'h0000);
      end
      chk_bit(alert_out, 1'b1);
      chk_bit(alert_oe, 1'b1);
      $display("test reset done");
   endtask
   task automatic t_math();
      host_u.reg_write(8'h05, 16'hffff);
      host_u.reg_read(8'h05, rd);
      check(rd, 16'h7fff);
      host_u.reg_write(8'h05, 16'h0800);
      host_u.send(16'h0100, 16'h0032);
      host_u.reg_read(8'h04, rd);
      check(rd, 16'h0100);
      host_u.reg_read(8'h03, rd);
      check(rd, 16'h0200);
      host_u.reg_read(8'h06, rd);
      check(rd, 16'h0008);
      host_u.reg_write(8'h05, 16'h7fff);
      host_u.send(16'h7fff, 16'h0001);
      host_u.reg_read(8'h06, rd);
      chk_bit(rd[pmra_pkg::OVERFLOW_POS], 1'b1);
      host_u.reg_write(8'h05, 16'h0800);
      host_u.send(16'h0100, 16'h0032);
      host_u.reg_read(8'h06, rd);
      chk_bit(rd[pmra_pkg::OVERFLOW_POS], 1'b0);
      $display("test math done");
   endtask
   task automatic t_limits();
      logic [15:0] ctl [5] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
         16'h0800};
      logic [15:0] tsh [5] = '{16'h0100, 16'h0010, 16'h0080, 16'h0080,
         16'h0100};
      logic [15:0] tbu [5] = '{16'h0080, 16'h0080, 16'h0100, 16'h0010,
         16'h0032};
      logic [15:0] cbu [5] = '{16'h0080, 16'h0080, 16'h0080, 16'h0080,
         16'h0019};
      host_u.reg_write(8'h07, 16'h0080);
      host_u.reg_read(8'h07, rd);
      check(rd, 16'h0080);
      for (int i = 0; i < 5; i++) begin
         host_u.reg_write(8'h06, ctl[i]);
         host_u.send(tsh[i], tbu[i]);
         chk_bit(alert_out, 1'b0);
         host_u.reg_read(8'h06, rd);
         chk_bit(rd[pmra_pkg::AFLAG_POS], 1'b1);
         host_u.send(16'h0080, cbu[i]);
         chk_bit(alert_out, 1'b1);
         host_u.reg_read(8'h06, rd);
         chk_bit(rd[pmra_pkg::AFLAG_POS], 1'b0);
      end
      $display("test limits done");
   endtask
   task automatic t_latch_pol();
      host_u.reg_write(8'h06, 16'h8001);
      host_u.send(16'h0100, 16'h0080);
      host_u.send(16'h0080, 16'h0080);
      chk_bit(alert_out, 1'b0);
      host_u.reg_read(8'h06, rd);
      chk_bit(rd[pmra_pkg::AFLAG_POS], 1'b1);
      repeat (2) @(negedge ref_clk);
      chk_bit(alert_out, 1'b1);
      host_u.reg_write(8'h06, 16'h9000);
      host_u.send(16'h0010, 16'h0010);
      chk_bit(alert_out, 1'b1);
      host_u.reg_write(8'h06, 16'h8002);
      host_u.send(16'h0080, 16'h0080);
      chk_bit(alert_out, 1'b0);
      host_u.send(16'h0100, 16'h0080);
      chk_bit(alert_out, 1'b1);
      $display("test latch and polarity done");
   endtask
   task automatic t_ready();
      host_u.reg_write(8'h06, 16'h0400);
      host_u.send(16'h0080, 16'h0080);
      chk_bit(alert_out, 1'b0);
      host_u.reg_read(8'h06, rd);
      chk_bit(rd[pmra_pkg::DONE_POS], 1'b1);
      host_u.reg_read(8'h06, rd);
      chk_bit(rd[pmra_pkg::DONE_POS], 1'b0);
      chk_bit(alert_out, 1'b1);
      host_u.send(16'h0080, 16'h0080);
      host_u.reg_write(8'h00, 16'h0003);
      host_u.reg_read(8'h06, rd);
      chk_bit(rd[pmra_pkg::DONE_POS], 1'b0);
      host_u.send(16'h0080, 16'h0080);
      host_u.reg_write(8'h00, 16'h0000);
      host_u.reg_read(8'h06, rd);
      chk_bit(rd[pmra_pkg::DONE_POS], 1'b1);
      op_mode = 3'h7;
      host_u.send(16'h0080, 16'h0080);
      host_u.reg_read(8'h06, rd);
      host_u.reg_read(8'h06, rd);
      chk_bit(rd[pmra_pkg::DONE_POS], 1'b1);
      op_mode = 3'h1;
      $display("test ready done");
   endtask
   initial begin
      rst = 1'b1;
      op_mode = 3'h1;
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      t_reset();
      t_math();
      t_limits();
      t_latch_pol();
      t_ready();
      report_and_stop();
   end
endmodule
